/* File: rtl/qwd_pkg.sv */
// package: constants for the quadrature watchdog
package qwd_pkg;
    localparam int unsigned count_width = 16;
    localparam int unsigned prescale_div = 64;
    localparam int unsigned prescale_width = 6;
    localparam logic [15:0] period_reset = 16'hFFFF;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [5:0] prescale_reset = 6'h00;
    localparam logic [5:0] prescale_last = 6'h3F;
endpackage

/* File: rtl/qwd_prescaler.sv */
// module: divides the main system clock into a one-cycle tick
`timescale 1ns/10ps
module qwd_prescaler (
    input wire logic ref_clk,
    input wire logic rst_n,
    qwd_tick_if.source tick_if
);
    logic [5:0] div_q;
    logic [5:0] div_d;
    logic tick_q;
    wire wrap = (div_q == qwd_pkg::prescale_last);

    assign div_d = wrap ? qwd_pkg::prescale_reset : div_q + 6'h01;
    assign tick_if.tick = tick_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= qwd_pkg::prescale_reset;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= wrap;
        end
    end
endmodule

/* File: rtl/qwd_tick_if.sv */
// interface: timebase tick between prescaler and watchdog core
`timescale 1ns/10ps
interface qwd_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface

/* File: rtl/qwd_watchdog.sv */
// module: quadrature supervision watchdog top
// Limitations
// a period written below a running count lets the count pass it and
// wrap once round the 16-bit range before the next match
// a period of zero times out on the cycle after any event
// event, period strobe and flag clear must already be on this clock
// the count parks at the period, so a late read shows where it stopped;
// trade: nothing records how long the encoder has been still since
// the prescaler is not cleared by events, so the first interval after
// an event is short by up to one tick
`timescale 1ns/10ps
module qwd_watchdog (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic qclk_event,
    input wire logic [15:0] period_value,
    input wire logic period_write,
    input wire logic flag_clear,
    output logic [15:0] count_value,
    output logic [15:0] period_readback,
    output logic timeout_flag
);
    // supervision phase: armed until one timeout, spent until an event
    // two states only: the flag itself is a separate register
    typedef enum logic {
        qwd_sup_armed,
        qwd_sup_spent
    } qwd_sup_state_type;

    // reset values, named once so each register block reads plainly;
    // the phase starts armed so a dead encoder is caught from power-up
    localparam logic [15:0] count_init = qwd_pkg::count_reset;
    localparam logic [15:0] period_init = qwd_pkg::period_reset;
    localparam qwd_sup_state_type state_init = qwd_sup_armed;

    // reset release chain; only the second stage feeds the core
    logic rst_sync1_q;
    logic rst_sync2_q;
    wire core_rst_n;

    // timebase tick from the prescaler
    qwd_tick_if tick_if ();
    wire tick_seen;

    // quadrature event, already on this clock
    wire event_seen;

    // supervision counter; width fixed by the ports
    logic [15:0] count_q;
    logic [15:0] count_d;
    wire [15:0] count_plus_one;
    wire [15:0] count_after_tick;
    wire count_clear;
    wire count_step;

    // period register and its compare
    logic [15:0] period_q;
    logic [15:0] period_d;
    wire period_match;

    // timeout flag
    logic flag_q;
    logic flag_d;
    wire flag_set;
    wire flag_drop;
    wire flag_after_clear;

    // supervision phase
    qwd_sup_state_type state_q;
    qwd_sup_state_type state_d;
    wire armed;
    wire rearm;
    wire spend;
    wire timeout_hit;

    // first stage may go metastable on release; nothing else reads it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
        end
    end

    // second stage is the only copy the core sees
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync2_q <= rst_sync1_q;
        end
    end

    assign core_rst_n = rst_sync2_q;

    // prescaler leaves reset with the core, so the first tick lands a
    // full divide after release and never part way through
    qwd_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .rst_n(core_rst_n),
        // one-cycle tick pulse, never a second clock
        .tick_if(tick_if.source)
    );

    // event and tick share this clock, so neither passes sync stages;
    // a held event simply keeps the count at zero
    assign event_seen = qclk_event;
    assign tick_seen = tick_if.tick;

    // compare count with the software period; a rewrite counts at once
    assign period_match = (count_q == period_q);
    // armed means no timeout yet since the last event
    assign armed = (state_q == qwd_sup_armed);

    // match only counts once per event, so a stalled encoder raises one
    // timeout rather than a flag that software cannot keep cleared
    assign timeout_hit = period_match && armed && !event_seen;

    // event has priority over the tick: a pulse restarts the interval
    assign count_clear = event_seen;

    // count parks at the period rather than wrapping past it
    assign count_step = tick_seen && !period_match;
    assign count_plus_one = count_q + 16'h0001;
    assign count_after_tick = count_step ? count_plus_one : count_q;
    assign count_d = count_clear ? count_init : count_after_tick;

    // load is immediate; there is no shadow copy
    assign period_d = period_write ? period_value : period_q;

    // set wins over a clear in the same cycle
    assign flag_set = timeout_hit;
    // software clear loses to a same-cycle set
    assign flag_drop = flag_clear && !flag_set;
    assign flag_after_clear = flag_drop ? 1'b0 : flag_q;
    assign flag_d = flag_set ? 1'b1 : flag_after_clear;

    // an event re-arms the phase; the flag itself only software drops
    assign rearm = event_seen;
    assign spend = timeout_hit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            // waiting for a match with no timeout since the last event
            qwd_sup_armed: begin
                if (spend) begin
                    state_d = qwd_sup_spent;
                end
            end

            // timed out; stays quiet until the encoder moves again
            qwd_sup_spent: begin
                if (rearm) begin
                    state_d = qwd_sup_armed;
                end
            end

            default: begin
                state_d = state_init;
            end
        endcase
    end

    // counter register
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            count_q <= count_init;
        end else begin
            count_q <= count_d;
        end
    end

    // period register, loaded only by the software strobe
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            // largest period, so an unprogrammed block times out late
            period_q <= period_init;
        end else begin
            period_q <= period_d;
        end
    end

    // sticky timeout flag
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // supervision phase register
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state_q <= state_init;
        end else begin
            state_q <= state_d;
        end
    end

    // every output is a register copy
    assign count_value = count_q;
    assign period_readback = period_q;
    assign timeout_flag = flag_q;
endmodule

/* File: tb/qwd_encoder_model.sv */
// partner model: encoder side issuing decoded quadrature clock events
`timescale 1ns/10ps
module qwd_encoder_model (
    input wire logic ref_clk,
    input wire logic step,
    output logic qclk_event = 1'b0
);
    // a step request becomes one event, launched on the next edge
    always @(posedge ref_clk) begin
        qclk_event <= step;
    end
endmodule

/* File: tb/qwd_watchdog_monitor.sv */
// checker: concurrent assertions on the watchdog's ports
`timescale 1ns/10ps
module qwd_monitor (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic qclk_event,
    input wire logic [15:0] period_value,
    input wire logic period_write,
    input wire logic flag_clear,
    input wire logic [15:0] count_value,
    input wire logic [15:0] period_readback,
    input wire logic timeout_flag
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_event_clear: assert property (
        qclk_event |=> count_value == 16'h0000)
        else $error("count not cleared by event");
    chk_count_step: assert property (
        $changed(count_value) |-> count_value == 16'h0000
        || count_value == $past(count_value) + 16'h0001)
        else $error("count jumped");
    chk_timeout_match: assert property (
        $rose(timeout_flag) |->
        $past(count_value) == $past(period_readback))
        else $error("timeout without period match");
    chk_flag_hold: assert property (
        $fell(timeout_flag) |-> $past(flag_clear))
        else $error("flag dropped without clear");
    chk_flag_stay: assert property (
        timeout_flag && !flag_clear |=> timeout_flag)
        else $error("flag lost while set");
    chk_count_park: assert property (
        count_value == period_readback && !qclk_event
        |=> count_value == $past(count_value))
        else $error("count moved past period");
    chk_period_load: assert property (
        period_write |=> period_readback == $past(period_value))
        else $error("period not loaded");

    cov_flag_set: cover property ($rose(timeout_flag));
    cov_flag_clear: cover property ($fell(timeout_flag));
    cov_event: cover property (qclk_event);
endmodule
bind qwd_watchdog qwd_monitor mon (.*);

/* File: tb/test_quadrature_watchdog.sv */
// bench: scenario tasks for the quadrature watchdog
`timescale 1ns/10ps
module test_quadrature_watchdog;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic step = 1'b0;
    logic period_write = 1'b0;
    logic flag_clear = 1'b0;
    logic [15:0] period_value = 16'h0000;
    logic qclk_event;
    logic timeout_flag;
    logic [15:0] count_value;
    logic [15:0] period_readback;
    int fails = 0;
    int checks_done = 0;
    int n;

    qwd_encoder_model enc (
        .ref_clk(ref_clk),
        .step(step),
        .qclk_event(qclk_event)
    );

    qwd_watchdog uut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .qclk_event(qclk_event),
        .period_value(period_value),
        .period_write(period_write),
        .flag_clear(flag_clear),
        .count_value(count_value),
        .period_readback(period_readback),
        .timeout_flag(timeout_flag)
    );

    initial begin
        forever begin
            #4 ref_clk = ~ref_clk;
        end
    end

    // drive just after each rising edge so the design samples settled values
    task cyc;
        @(posedge ref_clk);
        #1;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task stop_test;
        $display("fails %0d checks %0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // bounded wait for the count to reach v; a hang counts as a mismatch
    task upto(input logic [15:0] v);
        n = 0;
        while (count_value !== v && n <= 99) begin
            cyc;
            n++;
        end
        if (count_value !== v) begin
            fails++;
            stop_test;
        end
    endtask

    task time_out;
        period_value = 16'h0003;
        period_write = 1'b1;
        cyc;
        period_write = 1'b0;
        check(period_readback, 16'h0003);
        upto(16'h0001);
        upto(16'h0002);
        check(n, 16'h0040);
        upto(16'h0003);
        check(timeout_flag, 16'h0000);
        cyc;
        check(timeout_flag, 16'h0001);
    endtask

    task event_clear;
        step = 1'b1;
        cyc;
        step = 1'b0;
        cyc;
        check(count_value, 16'h0000);
        check(timeout_flag, 16'h0001);
        flag_clear = 1'b1;
        cyc;
        flag_clear = 1'b0;
        check(timeout_flag, 16'h0000);
    endtask

    // period zero matches at once: timeout meets a clear, then re-arm
    task set_wins;
        period_value = 16'h0000;
        period_write = 1'b1;
        cyc;
        period_write = 1'b0;
        flag_clear = 1'b1;
        cyc;
        flag_clear = 1'b0;
        check(timeout_flag, 16'h0001);
        flag_clear = 1'b1;
        cyc;
        flag_clear = 1'b0;
        check(timeout_flag, 16'h0000);
        repeat (70) cyc;
        check(timeout_flag, 16'h0000);
        check(count_value, 16'h0000);
        step = 1'b1;
        cyc;
        step = 1'b0;
        cyc;
        check(timeout_flag, 16'h0000);
        cyc;
        check(timeout_flag, 16'h0001);
    endtask

    task mid_reset;
        resetn = 1'b0;
        cyc;
        check(timeout_flag, 16'h0000);
        check(count_value, 16'h0000);
        check(period_readback, 16'hFFFF);
        resetn = 1'b1;
        cyc;
        cyc;
        check(timeout_flag, 16'h0000);
        check(count_value, 16'h0000);
        check(period_readback, 16'hFFFF);
        repeat (2) cyc;
    endtask

    initial begin
        repeat (4) cyc;
        resetn = 1'b1;
        repeat (3) cyc;
        time_out;
        event_clear;
        set_wins;
        mid_reset;
        stop_test;
    end
endmodule
